// file: logic/interrupt_priority_config.v
// Notes on behaviour
// - control bit 12 set selects multi-vectored mode, clear selects single; resets to 0.
// - proximity threshold 000 keeps the proximity timer disabled.
// - threshold N of 1..7 starts the timer for interrupts of priority N or lower.
// - each external input detects rising edge if its polarity bit is 1, else falling.
// - status bits 10..8 hold priority level of the latest presented interrupt.
// - status bits 5..0 hold vector number of the interrupt presented to the core.
// - every unimplemented bit reads as zero.
// - clear, set and invert aliases at base plus 0x4, 0x8, 0xC act on written ones; the status register has none.
// - usb priority fields exist only in the larger variant, else read zero.
// - priority field nonzero means level 1..7; zero disables the source.
// - subpriority field gives subpriority 0..3 directly.
// - timer start loads the count from the 32-bit reload register.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "irq_priority_config_regs.vh"
module interrupt_priority_config #(
    parameter LARGE_VARIANT = 1                   // 1 keeps the usb priority fields
) (
    input  wire         core_clk_i,               // system clock, 40 MHz
    input  wire         reset_i,                  // synchronous reset, active high
    input  wire [15:0]  reg_addr_i,               // register byte address
    input  wire [31:0]  reg_wdata_i,              // register write data
    input  wire         reg_wr_i,                 // write strobe
    input  wire         reg_rd_i,                 // read strobe
    output reg  [31:0]  reg_rdata_o,              // read data, cycle after strobe
    input  wire         irq_pending_i,            // arbiter has a winning request
    input  wire [2:0]   irq_level_i,              // its group priority
    input  wire [5:0]   irq_vector_i,             // its vector number
    output reg          core_irq_o,               // request presented to the core
    output reg  [2:0]   core_level_o,             // presented priority level
    output reg  [5:0]   core_vector_o,            // presented vector number
    output reg          proximity_busy_o,         // proximity timer counting
    input  wire [4:0]   ext_irq_i,                // external interrupt pins
    output wire [4:0]   ext_irq_flag_o,           // edge detected, one-cycle pulse
    output wire         multi_vector_select_o,    // 1 multi-vectored mode
    output wire [127:0] priority_table_o,         // four priority words, low first
    output wire [15:0]  source_enabled_o,         // priority field nonzero
    output wire [47:0]  source_priority_o,        // 3-bit level per source
    output wire [31:0]  source_subpriority_o      // 2-bit subpriority per source
);

    localparam [1:0] ST_IDLE     = 2'b01;
    localparam [1:0] ST_COUNTING = 2'b10;

    reg  [31:0] prio_serial_usb_cmp;
    reg  [31:0] prio_pport_cn_uart1;
    reg  [31:0] prio_touch_i2c2_uart2;
    reg  [31:0] prio_dma_channels;
    reg  [31:0] irq_global_control;
    reg  [31:0] irq_current_status;
    reg  [31:0] proximity_reload_value;
    reg  [31:0] proximity_count;
    reg  [1:0]  timer_state;
    reg         released;

    wire [15:0] base_addr;
    wire [1:0]  alias_op;
    wire [31:0] usb_mask;
    wire [31:0] prio_mask0;
    wire        multi_vector_select;
    wire [2:0]  proximity_threshold;
    wire [4:0]  ext_irq_polarity;
    wire        qualifies;
    wire        hold;
    wire        present;
    reg  [31:0] read_value;

    assign base_addr = {reg_addr_i[15:4], 4'h0};
    assign alias_op  = reg_addr_i[3:2];

    // usb fields only in the larger variant
    assign usb_mask   = (LARGE_VARIANT != 0) ? 32'h00000000 : `MASK_USB_FIELDS;
    assign prio_mask0 = `MASK_PRIORITY_CTRL & ~usb_mask;

    // plain, clear, set and invert writes
    function [31:0] alias_apply;
        input [31:0] old_value;
        input [31:0] wdata;
        input [1:0]  op;
        input [31:0] mask;
        begin
            case (op)
                `ALIAS_PLAIN:  alias_apply = wdata & mask;
                `ALIAS_CLEAR:  alias_apply = old_value & ~wdata & mask;
                `ALIAS_SET:    alias_apply = (old_value | wdata) & mask;
                `ALIAS_INVERT: alias_apply = (old_value ^ wdata) & mask;
                default:       alias_apply = old_value & mask;
            endcase
        end
    endfunction

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            prio_serial_usb_cmp    <= `RST_PRIORITY_CTRL;
            prio_pport_cn_uart1    <= `RST_PRIORITY_CTRL;
            prio_touch_i2c2_uart2  <= `RST_PRIORITY_CTRL;
            prio_dma_channels      <= `RST_PRIORITY_CTRL;
            irq_global_control     <= `RST_GLOBAL_CONTROL;
            proximity_reload_value <= `RST_PROXIMITY_RELOAD;
        end else if (reg_wr_i) begin
            case (base_addr)
                `OFF_PRIO_SERIAL_USB_CMP: begin
                    prio_serial_usb_cmp <= alias_apply(prio_serial_usb_cmp, reg_wdata_i,
                                                       alias_op, prio_mask0);
                end
                `OFF_PRIO_PPORT_CN_UART1: begin
                    prio_pport_cn_uart1 <= alias_apply(prio_pport_cn_uart1, reg_wdata_i,
                                                       alias_op, `MASK_PRIORITY_CTRL);
                end
                `OFF_PRIO_TOUCH_I2C2_U2: begin
                    prio_touch_i2c2_uart2 <= alias_apply(prio_touch_i2c2_uart2, reg_wdata_i,
                                                         alias_op, `MASK_PRIORITY_CTRL);
                end
                `OFF_PRIO_DMA_CHANNELS: begin
                    prio_dma_channels <= alias_apply(prio_dma_channels, reg_wdata_i,
                                                     alias_op, `MASK_PRIORITY_CTRL);
                end
                `OFF_GLOBAL_CONTROL: begin
                    irq_global_control <= alias_apply(irq_global_control, reg_wdata_i,
                                                      alias_op, `MASK_GLOBAL_CONTROL);
                end
                `OFF_PROXIMITY_RELOAD: begin
                    proximity_reload_value <= alias_apply(proximity_reload_value,
                                                          reg_wdata_i, alias_op,
                                                          32'hFFFFFFFF);
                end
                default: begin
                    proximity_reload_value <= proximity_reload_value;
                end
            endcase
        end
    end

    assign multi_vector_select   = irq_global_control[`BIT_MULTI_VECTOR];
    assign proximity_threshold   = irq_global_control[`POS_PROXIMITY_THRESHOLD +: 3];
    assign ext_irq_polarity      = irq_global_control[`POS_EXT_POLARITY +: 5];
    assign multi_vector_select_o = multi_vector_select;

    assign priority_table_o = {prio_dma_channels, prio_touch_i2c2_uart2,
                               prio_pport_cn_uart1, prio_serial_usb_cmp};

    genvar s;
    generate
        for (s = 0; s < `SOURCE_COUNT; s = s + 1) begin : g_src
            assign source_priority_o[s*3 +: 3] =
                priority_table_o[s*`FIELD_STRIDE + `POS_PRIORITY +: 3];
            assign source_enabled_o[s] = |source_priority_o[s*3 +: 3];
            assign source_subpriority_o[s*2 +: 2] =
                priority_table_o[s*`FIELD_STRIDE + `POS_SUBPRIORITY +: 2];
        end
    endgenerate

    ext_edge_detect u_ext_edge (
        .core_clk_i  (core_clk_i),
        .reset_i     (reset_i),
        .ext_irq_i   (ext_irq_i),
        .polarity_i  (ext_irq_polarity),
        .edge_flag_o (ext_irq_flag_o)
    );

    // level at or below threshold qualifies
    assign qualifies = irq_pending_i && (irq_level_i != 3'h0) &&
                       (proximity_threshold != 3'h0) &&
                       (irq_level_i <= proximity_threshold) && !released;

    // hold qualifying requests while timing; higher levels pass
    assign hold    = qualifies && !(timer_state == ST_COUNTING && proximity_count == 32'h0);
    assign present = irq_pending_i && (irq_level_i != 3'h0) && !hold;

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            timer_state      <= ST_IDLE;
            proximity_count  <= 32'h00000000;
            released         <= 1'b0;
            proximity_busy_o <= 1'b0;
        end else begin
            case (timer_state)
                ST_IDLE: begin
                    if (qualifies) begin
                        proximity_count  <= proximity_reload_value;
                        timer_state      <= ST_COUNTING;
                        proximity_busy_o <= 1'b1;
                    end
                    if (!irq_pending_i) begin
                        released <= 1'b0;
                    end
                end
                ST_COUNTING: begin
                    if (proximity_count == 32'h0) begin
                        timer_state      <= ST_IDLE;
                        proximity_busy_o <= 1'b0;
                        released         <= irq_pending_i;
                    end else begin
                        proximity_count <= proximity_count - 32'h1;
                    end
                end
                default: begin
                    timer_state      <= ST_IDLE;
                    proximity_busy_o <= 1'b0;
                end
            endcase
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            core_irq_o         <= 1'b0;
            core_level_o       <= 3'h0;
            core_vector_o      <= 6'h00;
            irq_current_status <= `RST_CURRENT_STATUS;
        end else begin
            core_irq_o <= present;
            if (present) begin
                core_level_o  <= irq_level_i;
                core_vector_o <= irq_vector_i;
                irq_current_status[`POS_PRESENTED_LEVEL +: 3] <= irq_level_i;
                irq_current_status[`POS_PRESENTED_VECTOR +: 6] <= irq_vector_i;
            end else if (reg_wr_i && reg_addr_i == `OFF_CURRENT_STATUS) begin
                irq_current_status <= reg_wdata_i & `MASK_CURRENT_STATUS;
            end
        end
    end

    // unimplemented bits and addresses read zero
    always @* begin
        read_value = 32'h00000000;
        if (alias_op == `ALIAS_PLAIN) begin
            case (base_addr)
                `OFF_PRIO_SERIAL_USB_CMP: read_value = prio_serial_usb_cmp & prio_mask0;
                `OFF_PRIO_PPORT_CN_UART1: read_value = prio_pport_cn_uart1;
                `OFF_PRIO_TOUCH_I2C2_U2:  read_value = prio_touch_i2c2_uart2;
                `OFF_PRIO_DMA_CHANNELS:   read_value = prio_dma_channels;
                `OFF_GLOBAL_CONTROL:      read_value = irq_global_control;
                `OFF_CURRENT_STATUS:      read_value = irq_current_status;
                `OFF_PROXIMITY_RELOAD:    read_value = proximity_reload_value;
                default:                  read_value = 32'h00000000;
            endcase
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= read_value;
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

endmodule // interrupt_priority_config

// file: logic/irq_priority_config_regs.vh
`ifndef IRQ_PRIORITY_CONFIG_REGS_VH
`define IRQ_PRIORITY_CONFIG_REGS_VH

// register byte offsets
`define ADDR_W                  16
`define OFF_GLOBAL_CONTROL      16'h1000
`define OFF_CURRENT_STATUS      16'h1010
`define OFF_PROXIMITY_RELOAD    16'h1020
`define OFF_PRIO_SERIAL_USB_CMP 16'h1100
`define OFF_PRIO_PPORT_CN_UART1 16'h1110
`define OFF_PRIO_TOUCH_I2C2_U2  16'h1120
`define OFF_PRIO_DMA_CHANNELS   16'h1130

// alias selector, address bits 3:2
`define ALIAS_PLAIN             2'h0
`define ALIAS_CLEAR             2'h1
`define ALIAS_SET               2'h2
`define ALIAS_INVERT            2'h3

// implemented bit masks
`define MASK_PRIORITY_CTRL      32'h1F1F1F1F
`define MASK_USB_FIELDS         32'h001F0000
`define MASK_GLOBAL_CONTROL     32'h0000171F
`define MASK_CURRENT_STATUS     32'h0000073F

// field positions
`define BIT_MULTI_VECTOR        12
`define POS_PROXIMITY_THRESHOLD 8
`define POS_EXT_POLARITY        0
`define POS_PRESENTED_LEVEL     8
`define POS_PRESENTED_VECTOR    0
`define FIELD_STRIDE            8
`define POS_SUBPRIORITY         0
`define POS_PRIORITY            2

// reset values
`define RST_PRIORITY_CTRL       32'h00000000
`define RST_GLOBAL_CONTROL      32'h00000000
`define RST_CURRENT_STATUS      32'h00000000
`define RST_PROXIMITY_RELOAD    32'h00000000

// counts
`define EXT_IRQ_COUNT           5
`define SOURCE_COUNT            16

`endif

// file: logic/ext_edge_detect.v
`timescale 1ns/1ps
module ext_edge_detect (
    input  wire       core_clk_i,    // system clock
    input  wire       reset_i,       // synchronous reset, active high
    input  wire [4:0] ext_irq_i,     // external interrupt pins
    input  wire [4:0] polarity_i,    // 1 rising, 0 falling
    output reg  [4:0] edge_flag_o    // one-cycle pulse per detected edge
);

    reg [4:0] sync_a;
    reg [4:0] sync_b;
    reg [4:0] sync_c;
    reg [4:0] pin_level;

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_pin
            always @(posedge core_clk_i) begin
                if (reset_i) begin
                    sync_a[g]      <= 1'b0;
                    sync_b[g]      <= 1'b0;
                    sync_c[g]      <= 1'b0;
                    pin_level[g]   <= 1'b0;
                    edge_flag_o[g] <= 1'b0;
                end else begin
                    sync_a[g]      <= ext_irq_i[g];
                    sync_b[g]      <= sync_a[g];
                    sync_c[g]      <= sync_b[g];
                    // a change counts once the last two stages agree
                    if (sync_b[g] == sync_c[g]) begin
                        pin_level[g] <= sync_c[g];
                    end
                    edge_flag_o[g] <= (sync_b[g] == sync_c[g]) && (sync_c[g] != pin_level[g]) &&
                                      (sync_c[g] == polarity_i[g]);
                end
            end
        end
    endgenerate

endmodule // ext_edge_detect

// file: testbench/irq_cfg_checker_assertions.sv
`timescale 1ns/1ps
`include "irq_priority_config_regs.vh"
module irq_cfg_checker (
    input wire        core_clk_i,            // clock
    input wire        reset_i,               // sync reset
    input wire [15:0] reg_addr_i,            // address
    input wire [31:0] reg_wdata_i,           // write data
    input wire        reg_wr_i,              // write strobe
    input wire        reg_rd_i,              // read strobe
    input wire [31:0] reg_rdata_o,           // read data
    input wire        irq_pending_i,         // request in
    input wire [2:0]  irq_level_i,           // level in
    input wire [5:0]  irq_vector_i,          // vector in
    input wire        core_irq_o,            // presented
    input wire [2:0]  core_level_o,          // presented level
    input wire [5:0]  core_vector_o,         // presented vector
    input wire        proximity_busy_o,      // timer running
    input wire [4:0]  ext_irq_i,             // pins
    input wire [4:0]  ext_irq_flag_o,        // edge pulses
    input wire        multi_vector_select_o  // mode
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence ctrl_write_s;
        reg_wr_i && reg_addr_i == `OFF_GLOBAL_CONTROL;
    endsequence
    sequence pin0_change_s;
        $past(ext_irq_i[0], 4) != $past(ext_irq_i[0], 5);
    endsequence

    mode_bit_a: assert property (
        ctrl_write_s |=> multi_vector_select_o == $past(reg_wdata_i[12]))
        else $error("mode bit differs from written value");
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h00000000)
        else $error("read data not zero outside read");
    status_zero_a: assert property (
        reg_rd_i && reg_addr_i == `OFF_CURRENT_STATUS |=>
        (reg_rdata_o & ~`MASK_CURRENT_STATUS) == 32'h00000000)
        else $error("status unused bits not zero");
    ctrl_zero_a: assert property (
        reg_rd_i && reg_addr_i == `OFF_GLOBAL_CONTROL |=>
        (reg_rdata_o & ~`MASK_GLOBAL_CONTROL) == 32'h00000000)
        else $error("control unused bits not zero");
    no_level0_a: assert property (
        core_irq_o |-> $past(irq_pending_i) && $past(irq_level_i) != 3'h0)
        else $error("request presented without enabled level");
    report_fields_a: assert property ($rose(core_irq_o) |->
        core_level_o == $past(irq_level_i) && core_vector_o == $past(irq_vector_i))
        else $error("presented level or vector wrong");
    drop_follow_a: assert property (!irq_pending_i |=> !core_irq_o)
        else $error("request kept after withdrawal");
    busy_cause_a: assert property ($rose(proximity_busy_o) |->
        $past(irq_pending_i) && $past(irq_level_i) != 3'h0)
        else $error("timer started without request");
    flag_pulse_a: assert property (ext_irq_flag_o[0] |=> !ext_irq_flag_o[0])
        else $error("edge flag longer than one cycle");
    flag_cause_a: assert property (ext_irq_flag_o[0] |-> pin0_change_s)
        else $error("edge flag without pin change");
endmodule // irq_cfg_checker

bind interrupt_priority_config irq_cfg_checker irq_cfg_checker_inst (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_pending_i(irq_pending_i), .irq_level_i(irq_level_i),
    .irq_vector_i(irq_vector_i), .core_irq_o(core_irq_o), .core_level_o(core_level_o),
    .core_vector_o(core_vector_o), .proximity_busy_o(proximity_busy_o),
    .ext_irq_i(ext_irq_i), .ext_irq_flag_o(ext_irq_flag_o),
    .multi_vector_select_o(multi_vector_select_o));

// file: testbench/core_model.sv
`timescale 1ns/1ps
module core_model (
    input  wire       core_clk_i,     // clock
    input  wire       reset_i,        // sync reset
    input  wire       irq_i,          // presented request
    input  wire [5:0] vector_i,       // presented vector
    input  wire       multi_i,        // multi-vectored mode
    output integer    taken_count_o,  // requests taken
    output reg  [5:0] last_vector_o   // vector of last request taken in single-vector mode
);
    reg irq_d;
    always @(posedge core_clk_i) begin
        irq_d <= irq_i;
        if (reset_i) begin
            taken_count_o <= 0;
            last_vector_o <= 6'h00;
        end else if (irq_i && !irq_d) begin
            taken_count_o <= taken_count_o + 1;
            if (!multi_i)
                last_vector_o <= vector_i;
        end
    end
endmodule // core_model

// file: testbench/interrupt_priority_config_tb.sv
`timescale 1ns/1ps
`include "irq_priority_config_regs.vh"
module interrupt_priority_config_tb;
    reg          core_clk_i = 1'b0;
    reg          reset_i = 1'b1;
    reg  [15:0]  reg_addr_i = 16'h0000;
    reg  [31:0]  reg_wdata_i = 32'h00000000;
    reg          reg_wr_i = 1'b0;
    reg          reg_rd_i = 1'b0;
    reg          irq_pending_i = 1'b0;
    reg  [2:0]   irq_level_i = 3'h0;
    reg  [5:0]   irq_vector_i = 6'h00;
    reg  [4:0]   ext_irq_i = 5'h00;
    wire [31:0]  reg_rdata_o;
    wire         core_irq_o, proximity_busy_o, multi_vector_select_o;
    wire [2:0]   core_level_o;
    wire [5:0]   core_vector_o, last_vector_o;
    wire [4:0]   ext_irq_flag_o;
    wire [127:0] priority_table_o;
    wire [15:0]  source_enabled_o;
    wire [47:0]  source_priority_o;
    wire [31:0]  source_subpriority_o;
    integer      n_fail = 0, check_count = 0, cycles = 0, n, taken_count_o;
    reg  [4:0]   seen;
    reg  [15:0]  a;

    always #12.5 core_clk_i = ~core_clk_i;

    interrupt_priority_config interrupt_priority_config_inst (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .irq_pending_i(irq_pending_i), .irq_level_i(irq_level_i),
        .irq_vector_i(irq_vector_i), .core_irq_o(core_irq_o), .core_level_o(core_level_o),
        .core_vector_o(core_vector_o), .proximity_busy_o(proximity_busy_o),
        .ext_irq_i(ext_irq_i), .ext_irq_flag_o(ext_irq_flag_o),
        .multi_vector_select_o(multi_vector_select_o), .priority_table_o(priority_table_o),
        .source_enabled_o(source_enabled_o), .source_priority_o(source_priority_o),
        .source_subpriority_o(source_subpriority_o));
    core_model core_model_inst (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .irq_i(core_irq_o),
        .vector_i(core_vector_o), .multi_i(multi_vector_select_o),
        .taken_count_o(taken_count_o), .last_vector_o(last_vector_o));
    // smaller variant: usb fields absent
    wire [127:0] small_table;
    interrupt_priority_config #(.LARGE_VARIANT(0)) interrupt_priority_config_small_inst (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(), .irq_pending_i(irq_pending_i), .irq_level_i(irq_level_i),
        .irq_vector_i(irq_vector_i), .core_irq_o(), .core_level_o(),
        .core_vector_o(), .proximity_busy_o(),
        .ext_irq_i(ext_irq_i), .ext_irq_flag_o(),
        .multi_vector_select_o(), .priority_table_o(small_table),
        .source_enabled_o(), .source_priority_o(),
        .source_subpriority_o());

    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [15:0] ad, input [31:0] d);
        begin
            @(posedge core_clk_i);
            reg_addr_i <= ad;
            reg_wdata_i <= d;
            reg_wr_i <= 1'b1;
            @(posedge core_clk_i);
            reg_wr_i <= 1'b0;
            #1;
        end
    endtask
    task rc(input [15:0] ad, input [31:0] exp);
        begin
            @(posedge core_clk_i);
            reg_addr_i <= ad;
            reg_rd_i <= 1'b1;
            @(posedge core_clk_i);
            reg_rd_i <= 1'b0;
            #1 check(reg_rdata_o, exp);
        end
    endtask
    // drive pins, collect edge flags from the launch edge on
    task pins(input [4:0] v);
        begin
            @(posedge core_clk_i);
            ext_irq_i <= v;
            #1 seen = ext_irq_flag_o;
            repeat (6) begin
                @(posedge core_clk_i);
                #1 seen = seen | ext_irq_flag_o;
            end
        end
    endtask
    task present(input [2:0] lv, input [5:0] vc);
        begin
            @(posedge core_clk_i);
            irq_pending_i <= 1'b1;
            irq_level_i <= lv;
            irq_vector_i <= vc;
            #1 n = 0;
            while (core_irq_o !== 1'b1 && n < 50) begin
                @(posedge core_clk_i);
                #1 n = n + 1;
            end
        end
    endtask
    task drop;
        begin
            @(posedge core_clk_i);
            irq_pending_i <= 1'b0;
            repeat (3) @(posedge core_clk_i);
        end
    endtask

    always @(posedge core_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            give_verdict;
        end
    end

    initial begin
        repeat (16) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rc(`OFF_GLOBAL_CONTROL, `RST_GLOBAL_CONTROL);
        rc(`OFF_CURRENT_STATUS, `RST_CURRENT_STATUS);
        rc(`OFF_PROXIMITY_RELOAD, `RST_PROXIMITY_RELOAD);
        rc(16'h1200, 32'h00000000);
        for (a = 16'h1100; a <= 16'h1130; a = a + 16'h0010) begin
            rc(a, `RST_PRIORITY_CTRL);
            wr(a, 32'hFFFFFFFF);
            rc(a, `MASK_PRIORITY_CTRL);
        end
        check(small_table[31:0], 32'h1F001F1F);
        wr(`OFF_PRIO_PPORT_CN_UART1, 32'h1F0B0700);
        check(priority_table_o[63:32], 32'h1F0B0700);
        check({16'h0000, source_enabled_o}, 32'h0000FFEF);
        check({20'h00000, source_priority_o[23:12]}, 32'h00000E88);
        check({24'h000000, source_subpriority_o[15:8]}, 32'h000000FC);
        $display("test priority done");
        wr(`OFF_PRIO_TOUCH_I2C2_U2, 32'h0F0F0F0F);
        wr(16'h1128, 32'h10100000);
        wr(16'h1124, 32'h01000001);
        wr(16'h112C, 32'h00000003);
        rc(`OFF_PRIO_TOUCH_I2C2_U2, 32'h1E1F0F0D);
        rc(16'h1128, 32'h00000000);
        wr(`OFF_CURRENT_STATUS, 32'hFFFFFFFF);
        rc(`OFF_CURRENT_STATUS, `MASK_CURRENT_STATUS);
        wr(16'h1014, 32'hFFFFFFFF);
        rc(`OFF_CURRENT_STATUS, `MASK_CURRENT_STATUS);
        wr(`OFF_CURRENT_STATUS, 32'h00000000);
        wr(16'h1008, 32'h00001000);
        check({31'h0, multi_vector_select_o}, 32'h00000001);
        wr(`OFF_GLOBAL_CONTROL, 32'hFFFFFFFF);
        rc(`OFF_GLOBAL_CONTROL, `MASK_GLOBAL_CONTROL);
        wr(16'h1004, 32'hFFFFFFFF);
        check({31'h0, multi_vector_select_o}, 32'h00000000);
        $display("test aliases done");
        wr(`OFF_GLOBAL_CONTROL, 32'h00000015);
        pins(5'h1F);
        check({27'h0, seen}, 32'h00000015);
        pins(5'h00);
        check({27'h0, seen}, 32'h0000000A);
        wr(`OFF_GLOBAL_CONTROL, 32'h0000000A);
        pins(5'h00);
        check({27'h0, seen}, 32'h00000000);
        $display("test edges done");
        wr(`OFF_GLOBAL_CONTROL, 32'h00000000);
        present(3'h3, 6'h11);
        check(n, 1);
        check({31'h0, proximity_busy_o}, 32'h00000000);
        drop;
        wr(`OFF_PROXIMITY_RELOAD, 32'h00000005);
        wr(`OFF_GLOBAL_CONTROL, 32'h00000300);
        present(3'h3, 6'h11);
        check(n, 7);
        rc(`OFF_CURRENT_STATUS, 32'h00000311);
        check({26'h0, last_vector_o}, 32'h00000011);
        drop;
        present(3'h4, 6'h04);
        check(n, 1);
        drop;
        @(posedge core_clk_i);
        irq_pending_i <= 1'b1;
        irq_level_i <= 3'h1;
        irq_vector_i <= 6'h03;
        repeat (2) @(posedge core_clk_i);
        #1 check({30'h0, proximity_busy_o, core_irq_o}, 32'h00000002);
        present(3'h5, 6'h2A);
        check(n, 1);
        check({29'h0, core_level_o}, 32'h00000005);
        check({26'h0, core_vector_o}, 32'h0000002A);
        rc(`OFF_CURRENT_STATUS, 32'h0000052A);
        drop;
        check(taken_count_o, 4);
        check({26'h0, last_vector_o}, 32'h0000002A);
        $display("test timer done");
        give_verdict;
    end
endmodule // interrupt_priority_config_tb
